// *** rtl/iec_pkg.sv ***
// input event counter: shared constants, register map and carrier types
// assumes one 200 MHz clock and a plain address/strobe register port
`default_nettype none
package iec_pkg;
  localparam int IEC_NCH = 8;
  localparam int IEC_AW = 8;
  localparam int IEC_DW = 32;
  localparam int IEC_DEBW = 16;
  // global registers
  localparam logic [7:0] IEC_OFF_STATUS = 8'h00;
  localparam logic [7:0] IEC_OFF_CMD = 8'h04;
  localparam logic [7:0] IEC_OFF_IRQ_ST = 8'h08;
  localparam logic [7:0] IEC_OFF_IRQ_MASK = 8'h0C;
  // per-channel window: base + channel * stride + register
  localparam logic [7:0] IEC_OFF_CH_BASE = 8'h40;
  localparam int IEC_CH_STRIDE_LSB = 4;
  localparam logic [3:0] IEC_OFF_CFG = 4'h0;
  localparam logic [3:0] IEC_OFF_DEB = 4'h4;
  localparam logic [3:0] IEC_OFF_PRE = 4'h8;
  localparam logic [3:0] IEC_OFF_CNT = 4'hC;
  // command and status field positions
  localparam int IEC_CMD_RESET_LSB = 0;
  localparam int IEC_CMD_ACLR_LSB = 8;
  localparam int IEC_STAT_EN_LSB = 8;
  localparam int IEC_CFG_W = 7;
  // reset values and terminal counts
  localparam logic [6:0] IEC_CFG_RST = 7'h00;
  localparam logic [15:0] IEC_DEB_RST = 16'h0000;
  localparam logic [31:0] IEC_PRE_RST = 32'h0000_0000;
  localparam logic [31:0] IEC_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] IEC_CNT_MAX = 32'hFFFF_FFFF;
  localparam logic [31:0] IEC_CNT_MIN = 32'h0000_0000;
  // debounce timebase
  localparam int IEC_CLK_KHZ = 200_000;
  localparam int IEC_DEB_STEP_MS = 1;
  localparam int IEC_MS_CYCLES = IEC_CLK_KHZ * IEC_DEB_STEP_MS;
  localparam int IEC_MSW = 18;

  // field order: bit 0 is enable, bit 6 is debounce enable
  typedef struct packed {
    logic deb_en;
    logic latch;
    logic alarm_en;
    logic start_pre;
    logic edge_rise;
    logic dir_down;
    logic en;
  } iec_cfg_s;

  typedef struct packed {
    logic vld;
    logic [31:0] val;
  } iec_load_s;
endpackage
`default_nettype wire

// *** rtl/iec_in_filter.sv ***
// input event counter: pin synchroniser, debounce filter, edge detector
// assumes a one-cycle millisecond tick from the top level
`default_nettype none
`timescale 1ns/1ps
module iec_in_filter import iec_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic i_ms_tick,
  input wire logic i_deb_en,
  input wire logic [15:0] i_deb_ms,
  input wire logic i_edge_rise,
  output logic o_edge
);
  logic sync1_q, sync2_q, level_q, level_d, edge_q, edge_d;
  logic [1:0] prime_q, prime_d;
  logic [15:0] ms_cnt_q, ms_cnt_d;

  always_comb begin
    level_d = level_q;
    ms_cnt_d = ms_cnt_q;
    prime_d = {prime_q[0], 1'b1};
    if (!prime_q[1]) begin
      level_d = sync2_q;
    end else if (sync2_q == level_q) begin
      ms_cnt_d = 16'h0000;
    end else if (!i_deb_en || i_deb_ms == 16'h0000) begin
      level_d = sync2_q;
    end else if (ms_cnt_q >= i_deb_ms && i_ms_tick) begin
      level_d = sync2_q;
      ms_cnt_d = 16'h0000;
    end else if (i_ms_tick) begin
      ms_cnt_d = ms_cnt_q + 16'h0001;
    end
    edge_d = prime_q[1] && (level_d != level_q) &&
      (level_d == i_edge_rise);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      level_q <= 1'b0;
      edge_q <= 1'b0;
      prime_q <= 2'h0;
      ms_cnt_q <= 16'h0000;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      level_q <= level_d;
      edge_q <= edge_d;
      prime_q <= prime_d;
      ms_cnt_q <= ms_cnt_d;
    end
  end

  assign o_edge = edge_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_debounce_hold: assert property (
    prime_q[1] && i_deb_en && i_deb_ms != 16'h0000 &&
    sync2_q != level_q && (ms_cnt_q < i_deb_ms || !i_ms_tick) |=>
    $stable(level_q))
    else $error("debounced level moved before the interval ran out");
  a_edge_sense: assert property (
    edge_q |-> level_q == $past(i_edge_rise) && $changed(level_q))
    else $error("edge reported with wrong polarity");
  c_deb_edge: cover property (i_deb_en && i_deb_ms != 16'h0000 && edge_q);
endmodule
`default_nettype wire

// *** rtl/iec_counter.sv ***
// input event counter: one 32-bit channel counter with alarm
// assumes a one-cycle count event and a one-cycle load from the top level
`default_nettype none
`timescale 1ns/1ps
module iec_counter import iec_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire iec_cfg_s i_cfg,
  input wire logic [31:0] i_pre,
  input wire logic i_evt,
  input wire iec_load_s i_load,
  input wire logic i_alarm_clr,
  output logic [31:0] o_count,
  output logic o_alarm,
  output logic o_alarm_evt
);
  logic [31:0] cnt_q, cnt_d, term;
  logic alarm_q, alarm_d, aevt_q, aevt_d;

  always_comb begin
    term = i_cfg.dir_down ? IEC_CNT_MIN : IEC_CNT_MAX;
    cnt_d = cnt_q;
    alarm_d = alarm_q;
    aevt_d = 1'b0;
    if (i_load.vld) begin
      cnt_d = i_load.val;
    end else if (i_cfg.en && i_evt) begin
      if (cnt_q == term) begin
        cnt_d = i_pre;
      end else if (i_cfg.dir_down) begin
        cnt_d = cnt_q - 32'h0000_0001;
      end else begin
        cnt_d = cnt_q + 32'h0000_0001;
      end
      if (i_cfg.alarm_en && cnt_d == term) begin
        alarm_d = 1'b1;
        aevt_d = 1'b1;
      end else if (!i_cfg.latch) begin
        alarm_d = 1'b0;
      end
    end
    if (i_alarm_clr && !aevt_d) begin
      alarm_d = 1'b0;
    end
    if (!i_cfg.alarm_en) begin
      alarm_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= IEC_CNT_RST;
      alarm_q <= 1'b0;
      aevt_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      alarm_q <= alarm_d;
      aevt_q <= aevt_d;
    end
  end

  assign o_count = cnt_q;
  assign o_alarm = alarm_q;
  assign o_alarm_evt = aevt_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_count_step: assert property (
    i_cfg.en && i_evt && !i_load.vld && cnt_q != term |=>
    cnt_q == ($past(i_cfg.dir_down) ? $past(cnt_q) - 32'h0000_0001 :
      $past(cnt_q) + 32'h0000_0001))
    else $error("counter did not step by one");
  a_rollover_preload: assert property (
    i_cfg.en && i_evt && !i_load.vld && cnt_q == term |=>
    cnt_q == $past(i_pre))
    else $error("rollover did not reload the preload value");
  a_alarm_terminal: assert property (
    i_cfg.alarm_en && i_cfg.en && i_evt && !i_load.vld &&
    cnt_d == term |=> alarm_q && aevt_q)
    else $error("alarm missed at terminal count");
  a_alarm_auto: assert property (
    alarm_q && !i_cfg.latch && i_cfg.en && i_evt && !i_load.vld &&
    cnt_d != term |=> !alarm_q)
    else $error("auto alarm not cleared on next count");
  a_alarm_latch: assert property (
    alarm_q && i_cfg.latch && i_cfg.alarm_en && !i_alarm_clr |=> alarm_q)
    else $error("latched alarm dropped without a clear");
  a_disabled_hold: assert property (
    !i_cfg.en && !i_load.vld |=> $stable(cnt_q))
    else $error("disabled counter moved");
  c_rollover: cover property (i_cfg.en && i_evt && cnt_q == term);
endmodule
`default_nettype wire

// *** rtl/iec_top.sv ***
// input event counter: eight channel counters behind a register port
// assumes asynchronous field inputs and a one-clock register master
`default_nettype none
`timescale 1ns/1ps
module iec_top import iec_pkg::*; #(
  parameter int MS_CYCLES = IEC_MS_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [7:0] i_pin,
  input wire logic [7:0] i_out_req,
  output logic [7:0] o_out,
  output logic [7:0] o_alarm,
  output logic o_irq,
  input wire logic i_restore,
  input wire logic [7:0][31:0] i_restore_cnt,
  output logic [7:0][31:0] o_save_cnt
);
  iec_cfg_s cfg_q [IEC_NCH];
  iec_cfg_s cfg_d [IEC_NCH];
  logic [15:0] deb_q [IEC_NCH];
  logic [15:0] deb_d [IEC_NCH];
  logic [31:0] pre_q [IEC_NCH];
  logic [31:0] pre_d [IEC_NCH];
  iec_load_s load [IEC_NCH];
  logic [7:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
  logic [7:0] out_q, out_d, en_vec, alarm_vec, aevt_vec, edge_vec;
  logic [7:0] aclr_vec;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] cnt_vec [IEC_NCH];
  logic [IEC_MSW-1:0] ms_cnt_q, ms_cnt_d;
  logic ms_tick_q, ms_tick_d;
  logic [IEC_MSW-1:0] tick_gap_q, tick_gap_d;
  logic [7:0] ch_off;
  logic [2:0] ch_sel;
  logic [3:0] reg_sel;
  logic ch_hit, wr_cmd, rd_irq_st;

  // channel window decode
  assign ch_off = i_addr - IEC_OFF_CH_BASE;
  assign ch_hit = (i_addr >= IEC_OFF_CH_BASE) && !ch_off[7];
  assign ch_sel = ch_off[6:4];
  assign reg_sel = ch_off[3:0];
  assign wr_cmd = i_wr && i_addr == IEC_OFF_CMD;
  assign rd_irq_st = i_rd && i_addr == IEC_OFF_IRQ_ST;

  // millisecond timebase for the debounce filters
  always_comb begin
    ms_tick_d = 1'b0;
    ms_cnt_d = ms_cnt_q + {{(IEC_MSW-1){1'b0}}, 1'b1};
    if (ms_cnt_q == IEC_MSW'(MS_CYCLES - 1)) begin
      ms_cnt_d = '0;
      ms_tick_d = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ms_cnt_q <= '0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_cnt_d;
      ms_tick_q <= ms_tick_d;
    end
  end

  // cycles since the last tick, watched by the tick spacing check
  always_comb begin
    tick_gap_d = tick_gap_q + {{(IEC_MSW-1){1'b0}}, 1'b1};
    if (ms_tick_q) begin
      tick_gap_d = {{(IEC_MSW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_gap_q <= '0;
    end else begin
      tick_gap_q <= tick_gap_d;
    end
  end

  // per-channel datapath
  for (genvar g = 0; g < IEC_NCH; g++) begin : g_ch
    iec_in_filter u_filter (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_pin(i_pin[g]),
      .i_ms_tick(ms_tick_q),
      .i_deb_en(cfg_q[g].deb_en),
      .i_deb_ms(deb_q[g]),
      .i_edge_rise(cfg_q[g].edge_rise),
      .o_edge(edge_vec[g])
    );
    iec_counter u_counter (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_cfg(cfg_q[g]),
      .i_pre(pre_q[g]),
      .i_evt(edge_vec[g]),
      .i_load(load[g]),
      .i_alarm_clr(aclr_vec[g]),
      .o_count(cnt_vec[g]),
      .o_alarm(alarm_vec[g]),
      .o_alarm_evt(aevt_vec[g])
    );
    assign en_vec[g] = cfg_q[g].en;
    assign o_save_cnt[g] = cnt_vec[g];
  end

  // counter loads: host write, reset command, then start-up restore
  always_comb begin
    for (int i = 0; i < IEC_NCH; i++) begin
      load[i] = '{vld: 1'b0, val: IEC_CNT_RST};
      aclr_vec[i] = wr_cmd && i_wdata[IEC_CMD_ACLR_LSB + i];
      if (i_wr && ch_hit && ch_sel == 3'(i) && reg_sel == IEC_OFF_CNT) begin
        load[i] = '{vld: 1'b1, val: i_wdata};
      end else if (wr_cmd && i_wdata[IEC_CMD_RESET_LSB + i]) begin
        load[i] = '{vld: 1'b1, val: pre_q[i]};
      end else if (i_restore) begin
        load[i].vld = 1'b1;
        load[i].val = cfg_q[i].start_pre ? pre_q[i] :
          i_restore_cnt[i];
      end
    end
  end

  // configuration, interrupt and output registers
  always_comb begin
    for (int i = 0; i < IEC_NCH; i++) begin
      cfg_d[i] = cfg_q[i];
      deb_d[i] = deb_q[i];
      pre_d[i] = pre_q[i];
      if (i_wr && ch_hit && ch_sel == 3'(i)) begin
        case (reg_sel)
          IEC_OFF_CFG: cfg_d[i] = iec_cfg_s'(i_wdata[IEC_CFG_W-1:0]);
          IEC_OFF_DEB: deb_d[i] = i_wdata[IEC_DEBW-1:0];
          IEC_OFF_PRE: pre_d[i] = i_wdata;
          default: ;
        endcase
      end
    end
    irq_mask_d = irq_mask_q;
    if (i_wr && i_addr == IEC_OFF_IRQ_MASK) begin
      irq_mask_d = i_wdata[7:0];
    end
    irq_st_d = irq_st_q;
    if (rd_irq_st) begin
      irq_st_d = 8'h00;
    end
    irq_st_d = irq_st_d | aevt_vec;
    out_d = i_out_req & ~en_vec;
  end

  // read mux, data valid only in the cycle after the strobe
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (i_rd) begin
      if (ch_hit) begin
        case (reg_sel)
          IEC_OFF_CFG: rdata_d = {25'h0, cfg_q[ch_sel]};
          IEC_OFF_DEB: rdata_d = {16'h0, deb_q[ch_sel]};
          IEC_OFF_PRE: rdata_d = pre_q[ch_sel];
          IEC_OFF_CNT: rdata_d = cnt_vec[ch_sel];
          default: rdata_d = 32'h0000_0000;
        endcase
      end else begin
        case (i_addr)
          IEC_OFF_STATUS: rdata_d = {16'h0, en_vec, alarm_vec};
          IEC_OFF_IRQ_ST: rdata_d = {24'h0, irq_st_q};
          IEC_OFF_IRQ_MASK: rdata_d = {24'h0, irq_mask_q};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < IEC_NCH; i++) begin
        cfg_q[i] <= IEC_CFG_RST;
        deb_q[i] <= IEC_DEB_RST;
        pre_q[i] <= IEC_PRE_RST;
      end
      irq_st_q <= 8'h00;
      irq_mask_q <= 8'h00;
      out_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < IEC_NCH; i++) begin
        cfg_q[i] <= cfg_d[i];
        deb_q[i] <= deb_d[i];
        pre_q[i] <= pre_d[i];
      end
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      out_q <= out_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_out = out_q;
  assign o_alarm = alarm_vec;
  assign o_irq = |(irq_st_q & irq_mask_q);

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_out_blocked: assert property (
    ##1 (o_out & $past(en_vec)) == 8'h00)
    else $error("output driven while its counter is enabled");
  a_irq_sticky: assert property (
    |aevt_vec |=> (irq_st_q & $past(aevt_vec)) == $past(aevt_vec))
    else $error("alarm event not captured in interrupt status");
  a_irq_read_clear: assert property (
    rd_irq_st && aevt_vec == 8'h00 |=> irq_st_q == 8'h00 && o_irq == 1'b0)
    else $error("interrupt status not cleared by its read");
  a_cfg_write: assert property (
    i_wr && ch_hit && reg_sel == IEC_OFF_CFG |=>
    cfg_q[$past(ch_sel)] == iec_cfg_s'($past(i_wdata[IEC_CFG_W-1:0])))
    else $error("configuration write not stored");
  a_count_write: assert property (
    i_wr && ch_hit && reg_sel == IEC_OFF_CNT |=>
    cnt_vec[$past(ch_sel)] == $past(i_wdata))
    else $error("count write not applied");
  a_rdata_idle: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data present without a read");
  a_tick_period: assert property (
    ms_tick_q && MS_CYCLES > 1 |=> !ms_tick_q)
    else $error("millisecond tick longer than one cycle");
  c_irq_raised: cover property (o_irq);
  c_restore: cover property (i_restore && en_vec != 8'h00);

  // register write, read-back and output release checks
  a_mask_write: assert property (
    i_wr && i_addr == IEC_OFF_IRQ_MASK |=> irq_mask_q == $past(i_wdata[7:0]))
    else $error("interrupt mask write not stored");
  a_deb_write: assert property (
    i_wr && ch_hit && reg_sel == IEC_OFF_DEB |=>
    deb_q[$past(ch_sel)] == $past(i_wdata[IEC_DEBW-1:0]))
    else $error("debounce time write not stored");
  a_pre_write: assert property (
    i_wr && ch_hit && reg_sel == IEC_OFF_PRE |=>
    pre_q[$past(ch_sel)] == $past(i_wdata))
    else $error("preload write not stored");
  a_count_read: assert property (
    i_rd && ch_hit && reg_sel == IEC_OFF_CNT |=>
    o_rdata == $past(cnt_vec[ch_sel]))
    else $error("count read returned a stale value");
  a_status_read: assert property (
    i_rd && i_addr == IEC_OFF_STATUS |=>
    o_rdata == {16'h0000, $past(en_vec), $past(alarm_vec)})
    else $error("status read does not match enables and alarms");
  a_out_release: assert property (
    en_vec == 8'h00 |=> o_out == $past(i_out_req))
    else $error("output not restored with all counters off");

  a_tick_spacing: assert property (
    ms_tick_q == (tick_gap_q == IEC_MSW'(MS_CYCLES)))
    else $error("millisecond tick spacing wrong");

  // per-channel command and start-up checks
  for (genvar g = 0; g < IEC_NCH; g++) begin : g_chk
    a_cmd_reload: assert property (
      wr_cmd && i_wdata[IEC_CMD_RESET_LSB + g] |=>
      cnt_vec[g] == $past(pre_q[g]))
      else $error("reset command did not reload the preload");
    a_restore_load: assert property (
      i_restore && !i_wr |=> cnt_vec[g] == ($past(cfg_q[g].start_pre) ?
      $past(pre_q[g]) : $past(i_restore_cnt[g])))
      else $error("start-up load took the wrong value");
    a_alarm_clear: assert property (
      wr_cmd && i_wdata[IEC_CMD_ACLR_LSB + g] |=>
      !alarm_vec[g] || aevt_vec[g])
      else $error("alarm clear command ignored");
  end
  c_cmd_reload: cover property (wr_cmd && i_wdata[IEC_CMD_RESET_LSB]);
endmodule
`default_nettype wire

// *** verif/iec_pulse_src.sv ***
// field pulse source: drives the eight counter inputs like contacts
// assumes a one-cycle request sampled on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module iec_pulse_src #(
  parameter int HALF = 60
) (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [2:0] i_ch,
  input wire logic [3:0] i_n,
  input wire logic i_bounce,
  output logic [7:0] o_pin,
  output var logic o_busy
);
  logic [2:0] ch_q;
  logic [3:0] n_q;
  logic b_q;
  // contacts are pulled up, so idle lines sit high
  initial begin
    o_pin = 8'hFF;
    o_busy = 1'b0;
  end
  // optional chatter of two short glitches before the level settles
  task automatic level(input logic v);
    if (b_q) begin
      repeat (2) begin
        o_pin[ch_q] <= v;
        repeat (3) @(posedge i_mclk);
        o_pin[ch_q] <= ~v;
        repeat (3) @(posedge i_mclk);
      end
    end
    o_pin[ch_q] <= v;
    repeat (HALF) @(posedge i_mclk);
  endtask
  always @(posedge i_mclk) begin
    if (i_go && !o_busy) begin
      ch_q = i_ch;
      n_q = i_n;
      b_q = i_bounce;
      o_busy <= 1'b1;
      repeat (n_q) begin
        level(1'b0);
        level(1'b1);
      end
      o_busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// input event counter bench: register master, pulse source, read checks
// assumes the counter top with a shortened debounce millisecond
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end
module testbench import iec_pkg::*; ;
  logic i_mclk, i_rst_n, i_wr, i_rd, o_irq, i_restore;
  logic [7:0] i_addr, i_out_req, o_out, o_alarm, pin;
  logic [31:0] i_wdata, o_rdata, e_mon, p, r;
  logic [7:0][31:0] i_restore_cnt, o_save_cnt, rc;
  logic go, pb, busy, rd_pend, d;
  logic [2:0] pch;
  logic [3:0] pn;
  logic [31:0] exp_q[$];
  int n_fail, n_compared, seed;
  iec_top #(.MS_CYCLES(10)) dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_pin(pin), .i_out_req(i_out_req), .o_out(o_out),
    .o_alarm(o_alarm), .o_irq(o_irq), .i_restore(i_restore),
    .i_restore_cnt(i_restore_cnt), .o_save_cnt(o_save_cnt));
  iec_pulse_src src_u (.i_mclk(i_mclk), .i_go(go), .i_ch(pch), .i_n(pn),
    .i_bounce(pb), .o_pin(pin), .o_busy(busy));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // read data stand in the cycle after the strobe
  always @(posedge i_mclk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("ERROR %0t: read data with no expectation", $time);
      end else begin
        e_mon = exp_q.pop_front();
        `CHK(o_rdata, e_mon)
      end
    end
    rd_pend <= i_rd;
  end
  function automatic logic [7:0] ca(input int c, input logic [3:0] o);
    return IEC_OFF_CH_BASE + 8'(c << IEC_CH_STRIDE_LSB) + {4'h0, o};
  endfunction
  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask
  task automatic start(input int c, input logic [3:0] n, input logic b);
    @(posedge i_mclk);
    go <= 1'b1;
    pch <= 3'(c);
    pn <= n;
    pb <= b;
    @(posedge i_mclk);
    go <= 1'b0;
  endtask
  task automatic finish;
    int k;
    for (k = 0; k < 5000; k++) begin
      @(posedge i_mclk);
      if (busy === 1'b0) break;
    end
    if (k == 5000) begin
      n_fail++;
      $display("ERROR %0t: pulse source hung", $time);
      results();
    end else begin
      cyc(10);
    end
  endtask
  task automatic pulse(input int c, input logic [3:0] n, input logic b);
    start(c, n, b);
    finish();
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    i_rst_n = 1'b0;
    {i_wr, i_rd, i_restore, go, pb, rd_pend} = 6'h00;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_out_req = 8'h00;
    i_restore_cnt = '0;
    pch = 3'h0;
    pn = 4'h0;
    n_fail = 0;
    n_compared = 0;
    seed = 5565;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    cyc(2);
    for (int c = 0; c < 8; c++) begin
      rd(ca(c, IEC_OFF_CFG), 32'h0);
      rd(ca(c, IEC_OFF_DEB), 32'h0);
      rd(ca(c, IEC_OFF_PRE), 32'h0);
      rd(ca(c, IEC_OFF_CNT), 32'h0);
    end
    rd(IEC_OFF_STATUS, 32'h0);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0);
    endt("reset");
    i_out_req <= 8'hFF;
    wr(ca(0, IEC_OFF_CFG), 32'h1);
    cyc(3);
    `CHK(o_out, 8'hFE)
    wr(ca(0, IEC_OFF_CFG), 32'h0);
    cyc(3);
    `CHK(o_out, 8'hFF)
    endt("output");
    for (int c = 0; c < 8; c++) begin
      wr(ca(c, IEC_OFF_CFG), 32'h1);
      pulse(c, 4'h1, 1'b0);
      rd(ca(c, IEC_OFF_CNT), 32'h1);
      wr(ca(c, IEC_OFF_CFG), 32'h0);
      pulse(c, 4'h1, 1'b0);
      rd(ca(c, IEC_OFF_CNT), 32'h1);
    end
    endt("channels");
    wr(ca(7, IEC_OFF_PRE), IEC_CNT_MAX);
    rd(ca(7, IEC_OFF_PRE), IEC_CNT_MAX);
    p = ($random(seed) & 32'h7FFF_FFFF) | 32'h100;
    wr(ca(0, IEC_OFF_PRE), p);
    wr(ca(0, IEC_OFF_CNT), 32'hFFFF_FFFE);
    wr(IEC_OFF_IRQ_MASK, 32'h1);
    wr(ca(0, IEC_OFF_CFG), 32'h11);
    start(0, 4'h1, 1'b0);
    cyc(12);
    rd(ca(0, IEC_OFF_CNT), IEC_CNT_MAX);
    finish();
    `CHK(o_alarm[0], 1'b1)
    `CHK(o_irq, 1'b1)
    rd(IEC_OFF_STATUS, 32'h101);
    rd(IEC_OFF_IRQ_ST, 32'h1);
    cyc(3);
    `CHK(o_irq, 1'b0)
    rd(IEC_OFF_IRQ_ST, 32'h0);
    pulse(0, 4'h1, 1'b0);
    rd(ca(0, IEC_OFF_CNT), p);
    `CHK(o_alarm[0], 1'b0)
    endt("up alarm");
    wr(ca(1, IEC_OFF_PRE), 32'h1);
    wr(ca(1, IEC_OFF_CNT), 32'h1);
    wr(ca(1, IEC_OFF_CFG), 32'h37);
    start(1, 4'h1, 1'b0);
    cyc(12);
    rd(ca(1, IEC_OFF_CNT), 32'h1);
    finish();
    rd(ca(1, IEC_OFF_CNT), 32'h0);
    `CHK(o_alarm[1], 1'b1)
    `CHK(o_irq, 1'b0)
    pulse(1, 4'h1, 1'b0);
    rd(ca(1, IEC_OFF_CNT), 32'h1);
    `CHK(o_alarm[1], 1'b1)
    rd(IEC_OFF_IRQ_ST, 32'h2);
    wr(IEC_OFF_CMD, 32'h200);
    cyc(2);
    `CHK(o_alarm[1], 1'b0)
    wr(ca(1, IEC_OFF_CNT), 32'h1234);
    wr(IEC_OFF_CMD, 32'h2);
    rd(ca(1, IEC_OFF_CNT), 32'h1);
    rd(IEC_OFF_CMD, 32'h0);
    endt("down latch");
    wr(ca(2, IEC_OFF_DEB), 32'hFFFF_FFFF);
    rd(ca(2, IEC_OFF_DEB), 32'h0000_FFFF);
    wr(ca(2, IEC_OFF_DEB), 32'h2);
    wr(ca(2, IEC_OFF_CFG), 32'h41);
    pulse(2, 4'h1, 1'b1);
    rd(ca(2, IEC_OFF_CNT), 32'h2);
    wr(ca(3, IEC_OFF_CFG), 32'h1);
    pulse(3, 4'h1, 1'b1);
    rd(ca(3, IEC_OFF_CNT), 32'h6);
    endt("debounce");
    r = $random(seed);
    wr(ca(5, IEC_OFF_PRE), r);
    wr(ca(5, IEC_OFF_CFG), 32'h9);
    for (int c = 0; c < 8; c++) begin
      rc[c] = $random(seed);
    end
    @(posedge i_mclk);
    i_restore_cnt <= rc;
    i_restore <= 1'b1;
    @(posedge i_mclk);
    i_restore <= 1'b0;
    cyc(2);
    for (int c = 0; c < 8; c++) begin
      rd(ca(c, IEC_OFF_CNT), (c == 5) ? r : rc[c]);
    end
    `CHK(o_save_cnt[4], rc[4])
    endt("start-up");
    for (int t = 0; t < 3; t++) begin
      p = ($random(seed) & 32'h7FFF_FFFF) | 32'h100;
      d = 1'($random(seed));
      pn = 4'(1 + ($unsigned($random(seed)) % 6));
      wr(ca(6, IEC_OFF_PRE), p);
      wr(IEC_OFF_CMD, 32'h40);
      wr(ca(6, IEC_OFF_CFG), {30'h0, d, 1'b1});
      pulse(6, pn, 1'b0);
      rd(ca(6, IEC_OFF_CNT), d ? p - 32'(pn) : p + 32'(pn));
    end
    endt("random");
    cyc(3);
    results();
  end
endmodule
`default_nettype wire
